/* hdl/emac_hbp_pkg.sv */
// constants for the group hash filter, backoff observation and tx pacing block
// assumes a 250 MHz pclk and 100 Mb/s media timing for slot and gap lengths
package emac_hbp_pkg;
  // ----------------------------------------
  // register byte offsets on the apb port
  // ----------------------------------------
  localparam logic [11:0] OFS_HASH_LOW  = 12'h000;  // group_hash_table_low
  localparam logic [11:0] OFS_HASH_HIGH = 12'h004;  // group_hash_table_high
  localparam logic [11:0] OFS_BACKOFF   = 12'h008;  // backoff_observe
  localparam logic [11:0] OFS_PACING    = 12'h00C;  // tx_pacing_observe
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RND_LSB  = 16;  // backoff_random_value 25:16
  localparam int TALLY_LSB = 12; // collision_tally 15:12
  localparam int SLOT_LSB = 0;   // backoff_slot_counter 9:0
  localparam int PACE_LSB = 0;   // pacing_counter 4:0
  localparam int IDX_W    = 6;   // hash index width
  localparam int DA_W     = 48;  // destination address width
  localparam logic [4:0] PACE_LOAD = 5'h1F;
  localparam logic [3:0] TALLY_MAX = 4'hF;
  localparam logic [9:0] RND_RST   = 10'h000;
  localparam int BACKOFF_LIMIT = 10; // exponent cap of the backoff window
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SLOT_TIME_PS  = 5120000; // 512 bit times at 100 Mb/s
  localparam int IPG_TIME_PS   = 960000;  // 96 bit times at 100 Mb/s
  localparam int SLOT_CYCLES   = SLOT_TIME_PS / CLK_PERIOD_PS;
  localparam int IPG_CYCLES    = IPG_TIME_PS / CLK_PERIOD_PS;
  localparam int PACE_GAPS     = 4;
  localparam logic [10:0] SLOT_LAST = 11'(SLOT_CYCLES - 1);
  localparam logic [9:0]  IPG_ONE   = 10'(IPG_CYCLES);
  localparam logic [9:0]  IPG_FOUR  = 10'(IPG_CYCLES * PACE_GAPS);

  // fold the address into six bits, bit i is xor of da[i], da[i+6] ...
  function automatic logic [5:0] hash_index(input logic [47:0] da);
    logic [5:0] h;
    h = 6'h00;
    for (int k = 0; k < DA_W / IDX_W; k++) begin
      h = h ^ da[k*IDX_W +: IDX_W];
    end
    return h;
  endfunction : hash_index

  // backoff window mask for a given collision count, capped at 2^10-1
  function automatic logic [9:0] backoff_mask(input logic [3:0] n);
    logic [9:0] m;
    m = 10'h000;
    for (int k = 0; k < BACKOFF_LIMIT; k++) begin
      if (k < int'(n)) begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : backoff_mask
endpackage : emac_hbp_pkg

/* hdl/backoff_rng.sv */
// ten bit free running generator for backoff slot selection
// assumes one clock and an active low asynchronous reset
`timescale 1ns/10ps
module backoff_rng (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic [9:0]      value_q
);
  // ----------------------------------------
  // xnor lfsr, all zero is a legal state so reset to zero works
  // ----------------------------------------
  logic fb;  // feedback tap x^10 + x^7 + 1
  assign fb = ~(value_q[9] ^ value_q[6]);

  // advance on every edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= emac_hbp_pkg::RND_RST;
    end else begin
      value_q <= {value_q[8:0], fb};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rng_moves;
    value_q != 10'h3FF |=> value_q != $past(value_q);
  endproperty
  a_rng_moves: assert property (p_rng_moves) else $error("rng stalled");
endmodule : backoff_rng

/* hdl/emac_hash_backoff_pacing.sv */
// group hash filter, backoff observation and transmit pacing of the mac
// assumes apb from software and single cycle event pulses from the tx path
//
// Contract
// - hash index xors address bits six apart
// - accept group frame when table bit set
// - low table word holds indexes 0..31
// - high table word holds indexes 32..63
// - random generator readable, reset zero, always runs
// - collision count of current frame readable
// - backoff counter loaded, decrements per slot
// - pacing counter loads 1Fh on collide/defer
// - good frame decrements pacing, floor zero
// - pacing active stretches gap to four
// - collided or deferred frame uses single gap
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module emac_hash_backoff_pacing (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  input  wire logic [47:0] rx_dest_addr,
  input  wire logic        rx_addr_valid,
  output logic             group_hit_q,
  output logic             group_hit_valid_q,
  input  wire logic        tx_frame_start,
  input  wire logic        tx_collision,
  input  wire logic        tx_deferred,
  input  wire logic        tx_good_frame,
  output logic             tx_gap_busy_q,
  output logic             backoff_busy_q
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] hash_low_q;       // table indexes 0..31
  logic [31:0] hash_high_q;      // table indexes 32..63
  logic [9:0]  rnd;              // backoff_random_value
  logic [3:0]  collision_tally_q;
  logic [9:0]  backoff_slot_counter_q;
  logic [4:0]  pacing_counter_q;
  logic [10:0] slot_div_q;       // slot time divider
  logic        slot_tick_q;      // one cycle per slot time
  logic [9:0]  gap_cnt_q;        // remaining gap cycles
  logic [3:0]  tally_d;          // count including this collision
  logic        setup;            // apb setup phase
  logic        access;           // apb completing access
  logic [31:0] rd_word;          // read mux
  logic        mapped;           // address decodes
  logic [5:0]  idx;              // hash of the incoming address
  logic [63:0] table_all;        // full hash table

  typedef enum logic [1:0] {
    GAP_IDLE = 2'b00,
    GAP_RUN  = 2'b01
  } gap_state_t;
  gap_state_t gap_state_q;

  backoff_rng u_rng (
    .pclk    (pclk),
    .presetn (presetn),
    .value_q (rnd)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup  = psel && !penable;
  assign access = psel && penable && pready_q;

  // decode, unmapped offsets answer with pslverr
  always_comb begin
    mapped  = 1'b1;
    rd_word = emac_hbp_pkg::RST_WORD;
    case (paddr)
      emac_hbp_pkg::OFS_HASH_LOW:  rd_word = hash_low_q;
      emac_hbp_pkg::OFS_HASH_HIGH: rd_word = hash_high_q;
      emac_hbp_pkg::OFS_BACKOFF: begin
        // reserved 31:26 and 11:10 stay zero
        rd_word[emac_hbp_pkg::RND_LSB +: 10]   = rnd;
        rd_word[emac_hbp_pkg::TALLY_LSB +: 4]  = collision_tally_q;
        rd_word[emac_hbp_pkg::SLOT_LSB +: 10]  = backoff_slot_counter_q;
      end
      emac_hbp_pkg::OFS_PACING: begin
        rd_word[emac_hbp_pkg::PACE_LSB +: 5] = pacing_counter_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // no wait state: data captured in setup, answered on the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= emac_hbp_pkg::RST_WORD;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q  <= pwrite ? emac_hbp_pkg::RST_WORD : rd_word;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // table writes; observe registers take no write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hash_low_q  <= emac_hbp_pkg::RST_WORD;
      hash_high_q <= emac_hbp_pkg::RST_WORD;
    end else if (access && pwrite) begin
      if (paddr == emac_hbp_pkg::OFS_HASH_LOW) begin
        hash_low_q <= pwdata;
      end
      if (paddr == emac_hbp_pkg::OFS_HASH_HIGH) begin
        hash_high_q <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // group hash filter
  // ----------------------------------------
  assign idx       = emac_hbp_pkg::hash_index(rx_dest_addr);
  assign table_all = {hash_high_q, hash_low_q};

  // registered verdict, one cycle after the address strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_hit_q       <= 1'b0;
      group_hit_valid_q <= 1'b0;
    end else begin
      group_hit_valid_q <= rx_addr_valid;
      if (rx_addr_valid) begin
        group_hit_q <= table_all[idx];
      end
    end
  end

  // ----------------------------------------
  // collision tally and backoff
  // ----------------------------------------
  assign tally_d = (collision_tally_q == emac_hbp_pkg::TALLY_MAX) ?
                   collision_tally_q : collision_tally_q + 4'h1;

  // tally restarts with each new frame; a collision in that cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collision_tally_q <= 4'h0;
    end else if (tx_collision) begin
      collision_tally_q <= tx_frame_start ? 4'h1 : tally_d;
    end else if (tx_frame_start) begin
      collision_tally_q <= 4'h0;
    end
  end

  // slot divider restarts at a collision so the first slot is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_div_q  <= 11'h000;
      slot_tick_q <= 1'b0;
    end else if (tx_collision || slot_div_q == emac_hbp_pkg::SLOT_LAST) begin
      slot_div_q  <= 11'h000;
      slot_tick_q <= !tx_collision;
    end else begin
      slot_div_q  <= slot_div_q + 11'h001;
      slot_tick_q <= 1'b0;
    end
  end

  // truncated binary exponential backoff, random draw masked by tally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backoff_slot_counter_q <= 10'h000;
    end else if (tx_collision) begin
      backoff_slot_counter_q <= rnd & emac_hbp_pkg::backoff_mask(
                                tx_frame_start ? 4'h1 : tally_d);
    end else if (slot_tick_q && backoff_slot_counter_q != 10'h000) begin
      backoff_slot_counter_q <= backoff_slot_counter_q - 10'h001;
    end
  end

  // busy while slots remain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backoff_busy_q <= 1'b0;
    end else begin
      backoff_busy_q <= (backoff_slot_counter_q != 10'h000);
    end
  end

  // ----------------------------------------
  // transmit pacing
  // ----------------------------------------
  // a bad event wins over a good frame reported in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pacing_counter_q <= 5'h00;
    end else if (tx_collision || tx_deferred) begin
      pacing_counter_q <= emac_hbp_pkg::PACE_LOAD;
    end else if (tx_good_frame && pacing_counter_q != 5'h00) begin
      pacing_counter_q <= pacing_counter_q - 5'h01;
    end
  end

  // gap timer; the stretch decision uses pacing as it stood at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_state_q <= GAP_IDLE;
      gap_cnt_q   <= 10'h000;
    end else if (tx_collision || tx_deferred) begin
      gap_state_q <= GAP_RUN;
      gap_cnt_q   <= emac_hbp_pkg::IPG_ONE;
    end else if (tx_good_frame) begin
      gap_state_q <= GAP_RUN;
      gap_cnt_q   <= (pacing_counter_q != 5'h00) ?
                     emac_hbp_pkg::IPG_FOUR : emac_hbp_pkg::IPG_ONE;
    end else begin
      case (gap_state_q)
        GAP_RUN: begin
          if (gap_cnt_q == 10'h001) begin
            gap_state_q <= GAP_IDLE;
          end
          gap_cnt_q <= gap_cnt_q - 10'h001;
        end
        default: begin
          gap_state_q <= GAP_IDLE;
          gap_cnt_q   <= 10'h000;
        end
      endcase
    end
  end

  // tx path must not start a new frame while this is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_gap_busy_q <= 1'b0;
    end else begin
      tx_gap_busy_q <= tx_collision || tx_deferred || tx_good_frame ||
                       (gap_state_q == GAP_RUN && gap_cnt_q != 10'h001);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hash_index;
    // all six bits, written as a fold of slices rather than through the package loop
    rx_addr_valid |-> idx == (rx_dest_addr[5:0] ^ rx_dest_addr[11:6] ^ rx_dest_addr[17:12] ^
      rx_dest_addr[23:18] ^ rx_dest_addr[29:24] ^ rx_dest_addr[35:30] ^ rx_dest_addr[41:36] ^
      rx_dest_addr[47:42]);
  endproperty
  a_hash_index: assert property (p_hash_index) else $error("hash index wrong");

  property p_hit;
    rx_addr_valid |=> group_hit_valid_q && group_hit_q == $past(table_all[idx]);
  endproperty
  a_hit: assert property (p_hit) else $error("group verdict wrong");

  property p_low_wr;
    access && pwrite && paddr == emac_hbp_pkg::OFS_HASH_LOW |=> hash_low_q == $past(pwdata);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low table write lost");

  property p_high_wr;
    access && pwrite && paddr == emac_hbp_pkg::OFS_HASH_HIGH |=> table_all[63:32] == $past(pwdata);
  endproperty
  a_high_wr: assert property (p_high_wr) else $error("high table write lost");

  property p_rnd_rd;
    setup && !pwrite && paddr == emac_hbp_pkg::OFS_BACKOFF |=> prdata_q[25:16] == $past(rnd);
  endproperty
  a_rnd_rd: assert property (p_rnd_rd) else $error("random field wrong");

  property p_tally;
    // expectation kept apart from tally_d so a broken increment still shows
    tx_collision && !tx_frame_start |=> collision_tally_q ==
      ($past(collision_tally_q) == 4'hF ? 4'hF : $past(collision_tally_q) + 4'h1);
  endproperty
  a_tally: assert property (p_tally) else $error("tally not counted");

  property p_backoff_dec;
    slot_tick_q && !tx_collision && backoff_slot_counter_q != 10'h000
      |=> backoff_slot_counter_q == $past(backoff_slot_counter_q) - 10'h001;
  endproperty
  a_backoff_dec: assert property (p_backoff_dec) else $error("backoff not decremented");

  // first collision of a frame draws from a window of two slots only
  property p_first_window;
    tx_collision && !tx_frame_start && collision_tally_q == 4'h0
      |=> backoff_slot_counter_q[9:1] == 9'h000;
  endproperty
  a_first_window: assert property (p_first_window) else $error("first backoff too wide");

  property p_pace_load;
    tx_collision || tx_deferred |=> pacing_counter_q == 5'h1F;
  endproperty
  a_pace_load: assert property (p_pace_load) else $error("pacing not loaded");

  property p_pace_dec;
    tx_good_frame && !tx_collision && !tx_deferred
      |=> pacing_counter_q == ($past(pacing_counter_q) == 5'h00 ? 5'h00 : $past(pacing_counter_q) - 5'h01);
  endproperty
  a_pace_dec: assert property (p_pace_dec) else $error("pacing decrement wrong");

  property p_gap_four;
    tx_good_frame && !tx_collision && !tx_deferred && pacing_counter_q != 5'h00
      |=> gap_cnt_q == emac_hbp_pkg::IPG_FOUR;
  endproperty
  a_gap_four: assert property (p_gap_four) else $error("gap not stretched");

  property p_gap_one;
    tx_collision || tx_deferred |=> gap_cnt_q == emac_hbp_pkg::IPG_ONE;
  endproperty
  a_gap_one: assert property (p_gap_one) else $error("gap stretched after bad frame");

  property p_pace_rd;
    setup && !pwrite && paddr == emac_hbp_pkg::OFS_PACING |=> prdata_q[31:5] == 27'h000_0000;
  endproperty
  a_pace_rd: assert property (p_pace_rd) else $error("reserved bits set");

  // reserved holes of the backoff word read back as zero
  property p_bo_rsv;
    setup && !pwrite && paddr == emac_hbp_pkg::OFS_BACKOFF
      |=> prdata_q[31:26] == 6'h00 && prdata_q[11:10] == 2'h0;
  endproperty
  a_bo_rsv: assert property (p_bo_rsv) else $error("backoff reserved bits set");

  // a write to the pacing word leaves the counter alone when no event competes
  property p_obs_wr;
    access && pwrite && paddr == emac_hbp_pkg::OFS_PACING &&
      !tx_collision && !tx_deferred && !tx_good_frame
      |=> pacing_counter_q == $past(pacing_counter_q);
  endproperty
  a_obs_wr: assert property (p_obs_wr) else $error("pacing changed by a write");

  c_hit: cover property (rx_addr_valid ##1 group_hit_q);
  c_pace: cover property (tx_deferred ##[1:20] tx_good_frame);
  c_slot: cover property (backoff_busy_q ##1 !backoff_busy_q);
  c_four: cover property (tx_good_frame && pacing_counter_q != 5'h00 ##1 tx_gap_busy_q);
endmodule : emac_hash_backoff_pacing

/* testbench/tx_event_model.sv */
// stand-in for the transmit side facing the mac: one-cycle event pulses
// assumes the bench calls pulse() from the pclk domain, one event at a time
`timescale 1ns/10ps
module tx_event_model (
  input  wire logic pclk,
  output logic      frame_start,
  output logic      collision,
  output logic      deferred,
  output logic      good_frame
);
  // ----------------------------------------
  // idle state
  // ----------------------------------------
  // all event lines idle low from time zero
  initial begin
    frame_start = 1'b0;
    collision   = 1'b0;
    deferred    = 1'b0;
    good_frame  = 1'b0;
  end

  // ----------------------------------------
  // event pulse
  // ----------------------------------------
  // kind 0 start, 1 collision, 2 deferral, 3 good frame
  // exactly one cycle high; a longer pulse would count twice
  task automatic pulse(input int kind);
    @(posedge pclk);
    case (kind)
      0: frame_start <= 1'b1;
      1: collision <= 1'b1;
      2: deferred <= 1'b1;
      default: good_frame <= 1'b1;
    endcase
    @(posedge pclk);
    {frame_start, collision, deferred, good_frame} <= 4'b0000;
  endtask : pulse
endmodule : tx_event_model

/* testbench/tb.sv */
// self-checking bench for the hash filter, backoff and pacing block
// assumes the apb answer and event timing stated by the designer
`timescale 1ns/10ps
module tb;
  localparam int          IPG  = emac_hbp_pkg::IPG_CYCLES;   // one gap
  localparam int          SLOT = emac_hbp_pkg::SLOT_CYCLES;  // one slot
  localparam logic [11:0] A_LO = emac_hbp_pkg::OFS_HASH_LOW;
  localparam logic [11:0] A_HI = emac_hbp_pkg::OFS_HASH_HIGH;
  localparam logic [11:0] A_BO = emac_hbp_pkg::OFS_BACKOFF;
  localparam logic [11:0] A_PC = emac_hbp_pkg::OFS_PACING;
  logic        pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd, rd2;
  logic [47:0] rx_dest_addr;
  logic        rx_addr_valid, group_hit_q, group_hit_valid_q, err;
  logic        tx_frame_start, tx_collision, tx_deferred, tx_good_frame;
  logic        tx_gap_busy_q, backoff_busy_q;
  int          failures, comparisons, cycles;

  // ----------------------------------------
  // clock, timeout, instances
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // the whole run needs about 33k cycles
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      failures++;
      print_verdict();
    end
  end
  emac_hash_backoff_pacing u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .rx_dest_addr(rx_dest_addr),
    .rx_addr_valid(rx_addr_valid), .group_hit_q(group_hit_q),
    .group_hit_valid_q(group_hit_valid_q), .tx_frame_start(tx_frame_start),
    .tx_collision(tx_collision), .tx_deferred(tx_deferred),
    .tx_good_frame(tx_good_frame), .tx_gap_busy_q(tx_gap_busy_q),
    .backoff_busy_q(backoff_busy_q));
  tx_event_model u_phy (
    .pclk(pclk), .frame_start(tx_frame_start), .collision(tx_collision),
    .deferred(tx_deferred), .good_frame(tx_good_frame));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready_q === 1'b1) break;
    end
    chk({31'h0, pready_q}, 32'h1, "ready");
    rd  = prdata_q;
    err = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bench's own fold: bit b of the address lands on index bit b mod 6
  function automatic logic [5:0] fold(input logic [47:0] da);
    logic [5:0] h;
    h = 6'h00;
    for (int b = 0; b < 48; b++) begin
      h[b % 6] = h[b % 6] ^ da[b];
    end
    return h;
  endfunction : fold

  // present one address, answer comes one cycle after it is taken
  task automatic probe(input logic [47:0] da, input logic hit);
    @(posedge pclk);
    rx_dest_addr  <= da;
    rx_addr_valid <= 1'b1;
    @(posedge pclk);
    rx_addr_valid <= 1'b0;
    @(posedge pclk);
    chk({30'h0, group_hit_valid_q, group_hit_q}, {30'h0, 1'b1, hit}, "hit");
  endtask : probe

  // one-hot table at idx, then a hit, a folded hit and a near miss
  task automatic hash_try(input logic [5:0] idx);
    logic [47:0] da;
    logic [63:0] tbl;
    da  = 48'h1234_5678_9abc ^ {42'h0, fold(48'h1234_5678_9abc) ^ idx};
    tbl = 64'h1 << idx;
    apb(1'b1, A_LO, tbl[31:0]);
    apb(1'b1, A_HI, tbl[63:32]);
    apb(1'b0, A_LO, 32'h0);
    chk(rd, tbl[31:0], "table low");
    apb(1'b0, A_HI, 32'h0);
    chk(rd, tbl[63:32], "table high");
    probe(da, 1'b1);
    probe(da ^ 48'h0c00_0000_0003, 1'b1);
    probe(da ^ 48'h0000_0100_0000, 1'b0);
  endtask : hash_try

  // fire an event and count the cycles the gap stays busy; busy stands for the gap itself
  task automatic gap(input int kind, input int want);
    int hi;
    hi = 0;
    u_phy.pulse(kind);
    for (int k = 0; k < 1200; k++) begin
      @(posedge pclk);
      if (tx_gap_busy_q === 1'b1) begin
        hi++;
      end else if (hi > 0) begin
        break;
      end
    end
    chk(hi, want, "gap length");
  endtask : gap

  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, rx_addr_valid} = 5'b00000;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    rx_dest_addr = 48'h0000_0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, reserved bits, running generator
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0, "pacing reset");
    apb(1'b0, A_BO, 32'h0);
    chk(rd & 32'hfc00_ffff, 32'h0, "backoff reset");
    rd2 = rd;
    apb(1'b0, A_BO, 32'h0);
    chk({31'h0, rd[25:16] != rd2[25:16]}, 32'h1, "generator runs");
    // unmapped place answers with an error and no data
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    hash_try(6'd0);
    hash_try(6'd31);
    hash_try(6'd32);
    hash_try(6'd63);
    hash_try(6'd45);
    // observe registers ignore writes
    apb(1'b1, A_PC, 32'hffff_ffff);
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0, "pacing write");
    // collisions until the backoff count is large enough to watch
    u_phy.pulse(0);
    for (int n = 1; n <= 12; n++) begin
      gap(1, IPG);
      apb(1'b0, A_BO, 32'h0);
      chk(rd[15:12], n, "tally");
      chk({31'h0, rd[9:0] <= (1 << n) - 1}, 32'h1, "window");
      if (rd[9:0] >= 10'd2) break;
    end
    chk({31'h0, backoff_busy_q}, 32'h1, "backoff busy");
    rd2 = rd;
    repeat (SLOT - 2) @(posedge pclk);
    apb(1'b0, A_BO, 32'h0);
    chk(rd[9:0], rd2[9:0] - 10'd1, "slot step");
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h1f, "pacing load");
    u_phy.pulse(0);
    apb(1'b0, A_BO, 32'h0);
    chk(rd[15:12], 4'h0, "tally clear");
    // pacing: stretched gaps, deferral reload, floor at zero
    gap(3, 4 * IPG);
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h1e, "pacing step");
    gap(2, IPG);
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h1f, "defer load");
    for (int k = 31; k > 0; k--) begin
      gap(3, 4 * IPG);
    end
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0, "pacing empty");
    gap(3, IPG);
    apb(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0, "pacing floor");
    print_verdict();
  end
endmodule : tb
